// *** core/adc_seq_pkg.sv ***
/*
  Package for the conversion sequencer: register offsets, field positions,
  reset values, timing constants and shared types.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package adc_seq_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] OFF_CONTROL_STATUS = 16'h1030;
  localparam logic [15:0] OFF_OPTION         = 16'h1034;
  localparam logic [15:0] OFF_LOWPOWER       = 16'h1038;
  localparam logic [15:0] OFF_RESULT_BASE    = 16'h1040;
  localparam logic [15:0] OFF_RESULT_LAST    = 16'h105C;

  // ************************************************************
  // Control/status fields
  // ************************************************************
  localparam int BIT_DONE  = 7;
  localparam int BIT_EIGHT_RESULT_SELECT = 6;
  localparam int BIT_SCAN  = 5;
  localparam int BIT_CHANNEL_GROUP_MODE  = 4;
  localparam int BIT_CSEL3 = 3;

  // Option fields
  localparam int BIT_POWER = 0;
  localparam int BIT_RCSEL = 1;
  localparam int BIT_DLY   = 2;

  // Low-power fields
  localparam int BIT_STOP  = 0;
  localparam int BIT_WAIT  = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [2:0] RST_OPTION  = 3'h0;
  localparam logic [1:0] RST_LOWPWR  = 2'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ            = 50;
  localparam int POWERUP_US         = 100;
  localparam int POWERUP_CYCLES     = POWERUP_US * CLK_MHZ;
  localparam int RC_START_MS        = 10;
  localparam int RC_START_CYCLES    = RC_START_MS * 1000 * CLK_MHZ;
  localparam int SET_OF_FOUR_CYCLES = 144;
  localparam int CONV_CYCLES        = SET_OF_FOUR_CYCLES / 4;
  localparam int SAMPLE_CYCLES      = CONV_CYCLES - 10;
  localparam int E_DIV              = 4;
  localparam int RC_DIV             = 33;
  localparam int RES_BITS           = 10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic       eight_result_select;
    logic       scan;
    logic       channel_group_mode;
    logic [3:0] chan;
  } seq_cfg_s;

  typedef struct packed {
    logic       we;
    logic [2:0] addr;
    logic [9:0] data;
  } res_wr_s;

endpackage

// *** core/adc_clk_div.sv ***
/*
  Enable-pulse divider: one-cycle pulse every DIV cycles of pclk.
  Assumes pclk free-running; run low holds the counter at zero.
*/
`timescale 1ns/1ps
module adc_clk_div #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic run,
  output logic      tick
);

  localparam int W = $clog2(DIV + 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_next;

  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == W'(DIV - 1)) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end

endmodule

// *** core/adc_result_mem.sv ***
/*
  Eight-word result store; one write port, registered read port.
  Assumes writer and reader on pclk.
*/
`timescale 1ns/1ps
module adc_result_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock
  input  wire logic                     pclk,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: result contents are undefined until first converted
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** core/adc_conversion_sequencer.sv ***
/*
  Conversion sequencer top: APB register slave, channel/slot sequencing,
  successive-approximation search and low-power handling.
  Assumes the comparator output is asynchronous and the stop/wait inputs come
  from the system's power controller as pins.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Single channel, four, continuous: keep converting, wrap over result slots 5 to 8.
// - Single channel, eight, single scan: slots 1 to 8 then halt until write.
// - Single channel, eight, continuous: ninth result goes to slot 1, wrap over all.
// - Multi channel, four: only top two select bits pick group 0-3, 4-7, 8-11 or 12-15.
// - Multi channel, four, single scan: group into slots 5 to 8, then stop.
// - Multi channel, four, continuous: cycle the group forever into slots 5 to 8.
// - Multi channel, eight, single scan: input n into slot n+1, low select bits ignored.
// - Multi channel, eight, continuous: all eight inputs, wrapping over slots 1 to 8.
// - Power enable low removes converter power; software waits 100 us after enabling.
// - Clock select 0 uses system clock, 1 uses internal oscillator near 1.5 MHz.
// - On system clock, switching and comparator sampling are synchronous to it.
// - Stop or wait mid-sequence suspends; resume re-samples channel and continues.
// - In stop, comparator, charge pump and oscillator are turned off.
// - Control register readable, writable any time; every write clears bit 7.
// - Done flag sets when a cycle of four or eight conversions completes.
// - In continuous modes done sets after first full pass, stays until write or power enable low.
// - Control write clears done, aborts conversion, restarts with new settings.
// - Eight-select 0 gives four conversions into four slots, 1 gives eight.
// - Scan 0 runs the selected count then stops; 1 repeats continuously.
// - Group mode 0 converts one channel repeatedly; 1 converts distinct channels.
// - Single channel, four, single scan: slots 5 to 8, then halt until write.
// - Results read left-justified in 16 bits, six low bits zero.
// - On the system clock each conversion takes 144 cycles, so a set of four takes 576.
// - Clearing power enable aborts a conversion in progress.
module adc_conversion_sequencer import adc_seq_pkg::*; #(
  parameter int RC_START_WAIT = RC_START_CYCLES
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Analog front end
  input  wire logic        comp_in,
  output logic [3:0]       mux_sel,
  output logic [9:0]       dac_code,
  output logic             sample_hold,
  output logic             analog_power,
  output logic             rc_osc_enable,
  // Power controller pins
  input  wire logic        stop_in,
  input  wire logic        wait_in
);

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_SAR} conv_state_e;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {wait_in, stop_in, comp_in};
      sync2_reg <= sync1_reg;
    end
  end

  logic comp_s;
  logic stop_s;
  logic wait_s;
  assign comp_s = sync2_reg[0];
  assign stop_s = sync2_reg[1];
  assign wait_s = sync2_reg[2];

  // ************************************************************
  // Register access
  // ************************************************************
  logic        acc;
  logic        wr_ctl;
  logic        wr_opt;
  logic        res_hit;
  logic [2:0]  res_idx;
  logic [9:0]  res_rdata;
  logic [6:0]  ctl_reg;
  logic [6:0]  ctl_next;
  logic [2:0]  opt_reg;
  logic [2:0]  opt_next;
  logic        done_reg;
  logic        done_next;
  logic        rd_phase_reg;
  logic        rd_phase_next;
  logic        pready_next;
  logic        pslverr_next;
  logic [31:0] prdata_next;

  assign acc     = psel && penable && !pready;
  assign wr_ctl  = acc && rd_phase_reg && pwrite && (paddr == OFF_CONTROL_STATUS);
  assign wr_opt  = acc && rd_phase_reg && pwrite && (paddr == OFF_OPTION);
  assign res_hit = (paddr >= OFF_RESULT_BASE) && (paddr <= OFF_RESULT_LAST) && (paddr[1:0] == 2'b00);
  assign res_idx = paddr[4:2];

  seq_cfg_s cfg;
  assign cfg = ctl_reg;

  // Two-cycle access: first access cycle lets the result memory read settle
  always_comb begin
    rd_phase_next = rd_phase_reg;
    pready_next   = 1'b0;
    pslverr_next  = 1'b0;
    prdata_next   = 32'h0000_0000;
    ctl_next      = ctl_reg;
    opt_next      = opt_reg;
    if (acc && !rd_phase_reg) begin
      rd_phase_next = 1'b1;
    end else if (acc) begin
      rd_phase_next = 1'b0;
      pready_next   = 1'b1;
      if (paddr == OFF_CONTROL_STATUS) begin
        prdata_next = {24'h0, done_reg, ctl_reg};
        if (pwrite) begin
          ctl_next = pwdata[6:0];
        end
      end else if (paddr == OFF_OPTION) begin
        prdata_next = {29'h0, opt_reg};
        if (pwrite) begin
          opt_next = pwdata[2:0];
        end
      end else if (paddr == OFF_LOWPOWER) begin
        prdata_next = {30'h0, wait_s, stop_s};
        pslverr_next = pwrite;
      end else if (res_hit) begin
        prdata_next = {16'h0, res_rdata, 6'h00};
        pslverr_next = pwrite;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_phase_reg <= 1'b0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0000_0000;
      ctl_reg      <= RST_CONTROL[6:0];
      opt_reg      <= RST_OPTION;
    end else begin
      rd_phase_reg <= rd_phase_next;
      pready       <= pready_next;
      pslverr      <= pslverr_next;
      prdata       <= prdata_next;
      ctl_reg      <= ctl_next;
      opt_reg      <= opt_next;
    end
  end

  // ************************************************************
  // Conversion clocking
  // ************************************************************
  logic power_on;
  logic rc_sel;
  logic tick_e;
  logic tick_rc;
  logic tick;
  logic run_clk;

  assign power_on = opt_reg[BIT_POWER];
  assign rc_sel   = opt_reg[BIT_RCSEL];
  // Oscillator stops in stop mode
  assign run_clk  = power_on && !stop_s;

  // System-clock rate: all steps tied to pclk enables
  adc_clk_div #(.DIV(E_DIV)) u_div_e (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_clk && !rc_sel),
    .tick    (tick_e)
  );

  // Oscillator stand-in; results still land on pclk, so at most one per cycle
  adc_clk_div #(.DIV(RC_DIV)) u_div_rc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run_clk && rc_sel),
    .tick    (tick_rc)
  );

  assign tick = rc_sel ? tick_rc : tick_e;

  // ************************************************************
  // Sequencer and search
  // ************************************************************
  conv_state_e st_reg;
  conv_state_e st_next;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic [9:0]  sar_reg;
  logic [9:0]  sar_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [3:0]  mux_next;
  logic        sh_next;
  res_wr_s     wr;
  logic        suspend;

  // Channel for a sequence position
  function automatic logic [3:0] chan_of(input seq_cfg_s c, input logic [2:0] i);
    logic [3:0] r;
    r = c.chan;
    if (c.channel_group_mode && c.eight_result_select) begin
      r = {1'b0, i};
    end else if (c.channel_group_mode) begin
      r = {c.chan[3:2], i[1:0]};
    end
    return r;
  endfunction

  // Result slot: four-conversion modes use slots 5 to 8
  function automatic logic [2:0] slot_of(input seq_cfg_s c, input logic [2:0] i);
    return c.eight_result_select ? i : {1'b1, i[1:0]};
  endfunction

  assign suspend = stop_s || wait_s;

  always_comb begin
    st_next   = st_reg;
    idx_next  = idx_reg;
    cnt_next  = cnt_reg;
    sar_next  = sar_reg;
    bit_next  = bit_reg;
    done_next = done_reg;
    mux_next  = mux_sel;
    sh_next   = 1'b0;
    wr        = '0;
    if (wr_ctl || !power_on) begin
      st_next   = power_on ? S_SAMPLE : S_IDLE;
      idx_next  = 3'h0;
      cnt_next  = 6'h00;
      done_next = 1'b0;
    end else if (suspend && st_reg != S_IDLE) begin
      st_next  = S_SAMPLE;
      cnt_next = 6'h00;
    end else if (tick) begin
      mux_next = chan_of(cfg, idx_reg);
      case (st_reg)
        S_SAMPLE: begin
          sh_next = 1'b1;
          if (cnt_reg == 6'(SAMPLE_CYCLES - 1)) begin
            st_next  = S_SAR;
            sar_next = 10'h200;
            bit_next = 4'd9;
          end else begin
            cnt_next = cnt_reg + 6'h01;
          end
        end
        S_SAR: begin
          if (!comp_s) begin
            sar_next[bit_reg] = 1'b0;
          end
          if (bit_reg != 4'd0) begin
            sar_next[bit_reg - 4'd1] = 1'b1;
            bit_next = bit_reg - 4'd1;
          end else begin
            wr.we    = 1'b1;
            wr.addr  = slot_of(cfg, idx_reg);
            wr.data  = sar_next;
            cnt_next = 6'h00;
            idx_next = idx_reg + 3'h1;
            if (idx_reg == (cfg.eight_result_select ? 3'h7 : 3'h3)) begin
              done_next = 1'b1;
              idx_next  = 3'h0;
              st_next   = cfg.scan ? S_SAMPLE : S_IDLE;
            end else begin
              st_next = S_SAMPLE;
            end
          end
        end
        default: begin
          st_next = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg        <= S_IDLE;
      idx_reg       <= 3'h0;
      cnt_reg       <= 6'h00;
      sar_reg       <= 10'h000;
      bit_reg       <= 4'h0;
      done_reg      <= 1'b0;
      mux_sel       <= 4'h0;
      sample_hold   <= 1'b0;
      dac_code      <= 10'h000;
      analog_power  <= 1'b0;
      rc_osc_enable <= 1'b0;
    end else begin
      st_reg        <= st_next;
      idx_reg       <= idx_next;
      cnt_reg       <= cnt_next;
      sar_reg       <= sar_next;
      bit_reg       <= bit_next;
      done_reg      <= done_next;
      mux_sel       <= mux_next;
      sample_hold   <= sh_next;
      dac_code      <= sar_next;
      analog_power  <= power_on && !stop_s;
      rc_osc_enable <= run_clk && rc_sel;
    end
  end

  adc_result_mem #(.WIDTH(RES_BITS), .DEPTH(8)) u_mem (
    .pclk  (pclk),
    .we    (wr.we),
    .waddr (wr.addr),
    .wdata (wr.data),
    .raddr (res_idx),
    .rdata (res_rdata)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  AST_WRITE_CLEARS_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> !done_reg) else $error("done flag not cleared by write");
  AST_POWER_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    !power_on |=> st_reg == S_IDLE) else $error("sequencer runs unpowered");
  AST_FOUR_SLOTS_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    wr.we && !cfg.eight_result_select |-> wr.addr[2]) else $error("four mode wrote low slot");
  AST_EIGHT_MULTI_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
    wr.we && cfg.eight_result_select && cfg.channel_group_mode |-> wr.addr == mux_sel[2:0]) else $error("slot mismatch");
  AST_SINGLE_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done_reg) && !cfg.scan && !wr_ctl |-> st_reg == S_IDLE) else $error("single scan kept running");
  AST_SCAN_CONTINUES: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(done_reg) && cfg.scan && power_on && !suspend |-> st_reg == S_SAMPLE) else $error("scan halted");
  AST_DONE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    done_reg && !wr_ctl && power_on |=> done_reg) else $error("done flag dropped");
  AST_STOP_POWERS_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
    stop_s |=> !analog_power && !rc_osc_enable) else $error("analog on in stop");
  AST_GROUP_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    wr.we && cfg.channel_group_mode && !cfg.eight_result_select |-> mux_sel[3:2] == cfg.chan[3:2]) else $error("group wrong");

endmodule

// *** testbench/adc_front_model.sv ***
/*
  Behavioural analog front end: channel mux, sample-and-hold and comparator.
  Assumes the sequencer drives mux_sel, dac_code and sample_hold from pclk.
*/
`timescale 1ns/1ps
module adc_front_model (
  // Clock
  input  wire logic       pclk,
  // From the sequencer
  input  wire logic [3:0] mux_sel,
  input  wire logic [9:0] dac_code,
  input  wire logic       sample_hold,
  input  wire logic       analog_power,
  // From the bench
  input  wire logic [9:0] shift,
  // To the sequencer
  output logic            comp_in
);
  logic [9:0] held_reg;
  logic       junk_reg = 1'b0;

  // ************************************************************
  // Sample and compare
  // ************************************************************
  // Channel k carries {k, 6'h2A} xor shift, so channels and passes differ
  always_ff @(posedge pclk) begin
    if (sample_hold) begin
      held_reg <= {mux_sel, 6'h2A} ^ shift;
    end
    junk_reg <= ~junk_reg;
  end

  // Unpowered comparator gives garbage, never a steady last value
  assign comp_in = analog_power ? (held_reg >= dac_code) : junk_reg;
endmodule

// *** testbench/adc_conversion_sequencer_tb_top.sv ***
/*
  Testbench top for the conversion sequencer: APB tasks, mode sweep,
  low-power, abort and clock-source tests.
  Assumes the front-end model and the core/ design files.
*/
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
  import adc_seq_pkg::*;
  localparam int          RC_WAIT = 2000;
  localparam logic [15:0] OFF_BAD = 16'h1060;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat;
  logic        pready, pslverr, rerr, comp_in, sample_hold, analog_power, rc_osc_enable;
  logic        stop_in = 1'b0, wait_in = 1'b0;
  logic [3:0]  mux_sel;
  logic [9:0]  dac_code, shift = 10'h000, sh0;
  int          err_count = 0, total_checks = 0, cyc_cnt = 0, hi_cnt = 0, n, cyc, h0;
  seq_cfg_s    cfg;

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (sample_hold === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
  end

  adc_conversion_sequencer #(.RC_START_WAIT(RC_WAIT)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .comp_in(comp_in), .mux_sel(mux_sel), .dac_code(dac_code), .sample_hold(sample_hold),
    .analog_power(analog_power), .rc_osc_enable(rc_osc_enable), .stop_in(stop_in),
    .wait_in(wait_in));

  adc_front_model i_front (
    .pclk(pclk), .mux_sel(mux_sel), .dac_code(dac_code), .sample_hold(sample_hold),
    .analog_power(analog_power), .shift(shift), .comp_in(comp_in));

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    chk(32'(k), 3, "pready wait");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [31:0] expv(input seq_cfg_s c, input int s, input logic [9:0] sh);
    logic [3:0] ch;
    ch = !c.channel_group_mode ? c.chan : (c.eight_result_select ? 4'(s) : {c.chan[3:2], 2'(s)});
    return {16'h0000, {ch, 6'h2A} ^ sh, 6'h00};
  endfunction

  task automatic chk_slots(input seq_cfg_s c, input logic [9:0] sh);
    for (int s = (c.eight_result_select ? 0 : 4); s < 8; s++) begin
      apb(1'b0, OFF_RESULT_BASE + 16'(4 * s), 32'h0);
      chk(rdat, expv(c, s, sh), "result slot");
    end
  endtask

  task automatic wait_done(input int lim);
    int t0;
    t0 = cyc_cnt;
    do apb(1'b0, OFF_CONTROL_STATUS, 32'h0); while (rdat[BIT_DONE] !== 1'b1 && cyc_cnt - t0 < lim);
    cyc = cyc_cnt - t0;
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
    chk(rdat, {24'h0, RST_CONTROL}, "control after reset");
    apb(1'b0, OFF_BAD, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped read");
    apb(1'b1, OFF_RESULT_BASE, 32'hFFFF);
    chk(32'(rerr), 1, "result write refused");
    apb(1'b1, OFF_OPTION, 32'h1);
    apb(1'b0, OFF_OPTION, 32'h0);
    chk(rdat, 32'h1, "option readback");
    repeat (POWERUP_CYCLES) @(posedge pclk);
    chk(32'(analog_power), 1, "power on");
    $display("Test registers finished");
    // Every mode; bit 7 written high, slot contents made unique per mode
    for (int m = 0; m < 8; m++) begin
      cfg = seq_cfg_s'({m[2:0], 1'b0, m[2:0] ^ 3'h5});
      n = cfg.eight_result_select ? 8 : 4;
      sh0 = 10'(m) << 7;
      shift <= sh0;
      apb(1'b1, OFF_CONTROL_STATUS, {24'h0, 1'b1, cfg});
      apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
      chk(rdat, {24'h0, 1'b0, cfg}, "control after write");
      wait_done(2000);
      chk(32'(cyc > n * 144 - 64 && cyc < n * 144 + 64), 1, "sequence time");
      chk_slots(cfg, sh0);
      shift <= sh0 ^ 10'h155;
      h0 = hi_cnt;
      repeat (n * 144 + 300) @(posedge pclk);
      chk(32'(hi_cnt != h0), 32'(cfg.scan), "sampling after done");
      chk_slots(cfg, cfg.scan ? sh0 ^ 10'h155 : sh0);
      apb(1'b0, OFF_CONTROL_STATUS, 32'h0);
      chk(32'(rdat[BIT_DONE]), 1, "done stays set");
      $display("Test mode %0d finished", m);
    end
    // Stop then wait in mid-sequence
    cfg = seq_cfg_s'(7'h53);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CONTROL_STATUS, {25'h0, cfg});
      repeat (300) @(posedge pclk);
      stop_in <= (k == 0);
      wait_in <= (k == 1);
      repeat (20) @(posedge pclk);
      chk(32'(analog_power), 32'(k), "power in low-power state");
      apb(1'b0, OFF_LOWPOWER, 32'h0);
      chk(rdat, 32'(1 << k), "low-power status");
      repeat (200) @(posedge pclk);
      stop_in <= 1'b0;
      wait_in <= 1'b0;
      repeat (POWERUP_CYCLES) @(posedge pclk);
      wait_done(2000);
      chk(32'(rdat[BIT_DONE]), 1, "done after resume");
      chk_slots(cfg, shift);
    end
    $display("Test low power finished");
    apb(1'b1, OFF_CONTROL_STATUS, {25'h0, cfg});
    repeat (300) @(posedge pclk);
    apb(1'b1, OFF_OPTION, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(analog_power), 0, "power off");
    wait_done(1500);
    chk(32'(rdat[BIT_DONE]), 0, "aborted sequence");
    $display("Test abort finished");
    apb(1'b1, OFF_OPTION, 32'h3);
    repeat (RC_WAIT) @(posedge pclk);
    chk(32'(rc_osc_enable), 1, "oscillator on");
    apb(1'b1, OFF_CONTROL_STATUS, {25'h0, cfg ^ 7'h40});
    wait_done(8000);
    chk(32'(rdat[BIT_DONE] && cyc > 4 * 144 + 64), 1, "oscillator timing");
    stop_in <= 1'b1;
    repeat (20) @(posedge pclk);
    chk({rc_osc_enable, analog_power}, 0, "stop powers down");
    stop_in <= 1'b0;
    $display("Test clock source finished");
    end_sim();
  end
endmodule
